// *** timer_core_sva.sv ***
/* Port checker for the timer core: APB timing and pin enables.
   Assumes the header map and a bind onto every core instance. */
`timescale 1ns/1ps
`include "timer_counter_map.vh"
module timer_core_sva (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [3:0] timer_pin_oe
);
   wire [7:0] a = paddr[7:0];
   // Aligned holes in the map; unaligned ones are left alone
   wire unm = a[1:0] == 2'h0 && (a == 8'h34 || a == 8'h3C || a > 8'h44);
   reg [3:0] func_q;
   // Shadow of the function select, written at the completion edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) func_q <= 4'h0;
      else if (psel && penable && pready && pwrite && a == `OFS_FUNC_SEL)
         func_q <= pwdata[3:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence done_s; psel && penable && pready; endsequence
   ready_after_setup_a: assert property (setup_s |=> done_s)
      else $error("ready missing after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   ready_one_cycle_a: assert property (done_s |=> !pready)
      else $error("ready held too long");
   err_reads_zero_a: assert property (pslverr |-> pready && prdata == 0)
      else $error("error without ready or zero data");
   unmapped_err_a: assert property (pready && unm |-> pslverr)
      else $error("hole answered without error");
   mapped_ok_a: assert property (pready && !unm &&
      a[1:0] == 2'h0 |-> !pslverr) else $error("mapped register refused");
   force_reads_zero_a: assert property (pready && !pwrite &&
      a == `OFS_FORCE |-> prdata == 0) else $error("force reads nonzero");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 0)
      else $error("upper read bits set");
   oe_follows_sel_a: assert property (timer_pin_oe == func_q ||
      timer_pin_oe == $past(func_q)) else $error("enable differs from select");
endmodule // timer_core_sva
bind timer_counter_control_core timer_core_sva chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_pin_oe(timer_pin_oe));

// *** timer_counter_control_core.v ***
/*
 * Four-channel 16-bit timer core: free-running counter, prescaler,
 * compare and capture per channel, channel 3 override, toggle on
 * overflow, fast flag clearing, a simple pulse accumulator, and an
 * APB slave with a masked level interrupt.
 * Assumes pin inputs and test_mode are synchronous to pclk.
 */
`timescale 1ns/1ps
`include "timer_counter_map.vh"

module timer_counter_control_core (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire test_mode,
   input wire [3:0] timer_pin_in,
   output reg [3:0] timer_pin_out,
   output reg [3:0] timer_pin_oe,
   output reg irq
);

   // Register layout, byte offsets on paddr[7:0], data in the low bits:
   //   00 function select, one bit per channel, 1 = output compare
   //   04 force strobe, acts one cycle after the write, reads 0
   //   08 override mask, pins that follow a channel 3 compare
   //   0C override data, levels those pins take
   //   10 counter, written only in test mode
   //   14 control one, bit 7 global enable, bit 4 fast clear
   //   18 toggle-on-overflow enables
   //   1C control two, bit 3 reset on ch3, bits 2:0 prescale exponent
   //   20 flags: 3:0 channels, 4 overflow, 5 and 6 accumulator
   //   24 to 30 channel compare or capture values
   //   38 accumulator counter
   //   40 interrupt mask, same layout as the flags
   //   44 port data, compare actions override a write in one cycle
   //   Any other offset answers with pslverr and changes nothing

   // Bus timing: pready rises in the cycle after setup, so every
   // transfer takes exactly one access cycle; read data is sampled
   // at the setup edge and stands with pready for one cycle.
   // Writes and fast-clear side effects act at the completion edge.

   // Counting: one tick every 2^n bus cycles, n from control two;
   // compares look at the count before it steps, so a match flags at
   // the tick where the counter leaves the compare value.
   // Limitation: a counter write restarts the prescaler, so the first
   // count after it may be one prescale period late.

   // Pin priority on an output-compare channel, highest first:
   //   channel 3 compare with its mask bit set: take the override data
   //   counter wrap from all ones with the toggle bit set, a ch3 reset there included: invert the pin
   //   own compare or a force strobe: invert the pin once
   // Pins show the result one clock after the event, from flip-flops.

   // Flags are sticky; a new event in the same cycle as a clear wins,
   // so no event is lost to software that clears late.
   // Fast clear trades the write-one clear for side effects of normal
   // reads and writes; while it is on, flag writes are ignored.

   // Accumulator: counts rising edges on pin 3 while the timer runs
   // and channel 3 is an input; sets its input flag on every edge and
   // its overflow flag at the wrap from all ones.

   // Interrupt: registered OR of the masked next flags, so it follows the
   // flags in the same clock and drops in the same clock as the clear.

   // Next pin value of one channel, highest priority first
   function next_pin;
      input cur;
      input ovr_hit;
      input ovr_val;
      input tog_ovf;
      input cmp_or_force;
      begin
         if (ovr_hit) begin
            next_pin = ovr_val;
         end else if (tog_ovf) begin
            next_pin = ~cur;
         end else if (cmp_or_force) begin
            next_pin = ~cur;
         end else begin
            next_pin = cur;
         end
      end
   endfunction

   // Byte offset of channel register n; channels sit four bytes apart
   function [7:0] ch_ofs;
      input [1:0] n;
      begin
         ch_ofs = `OFS_CH0 + {4'h0, n, 2'b00};
      end
   endfunction

   reg [3:0] func_sel_q;
   reg [3:0] ovr_mask_q;
   reg [3:0] ovr_data_q;
   reg [7:0] sys_ctrl1_q;
   reg [3:0] tog_ovf_q;
   reg [7:0] sys_ctrl2_q;
   reg [6:0] flags_q;
   reg [6:0] flags_d;
   reg [6:0] irq_mask_q;
   reg [15:0] count_q;
   reg [15:0] count_d;
   reg [15:0] ch_q [0:3];
   reg [15:0] acc_q;
   reg [6:0] presc_q;
   reg [3:0] pin_in_q;
   reg [3:0] port_q;
   reg [3:0] port_d;
   reg [3:0] force_q;

   wire setup = psel & ~penable;
   wire done = psel & penable & pready;
   wire wr = done & pwrite;
   wire rd = done & ~pwrite;
   wire [7:0] ofs = paddr[7:0];

   // Write strobes, one per writable register but the counter and channels, valid at completion
   wire wr_func_sel = wr & (ofs == `OFS_FUNC_SEL);
   wire wr_force = wr & (ofs == `OFS_FORCE);
   wire wr_ovr_mask = wr & (ofs == `OFS_OVR_MASK);
   wire wr_ovr_data = wr & (ofs == `OFS_OVR_DATA);
   wire wr_sys_ctrl1 = wr & (ofs == `OFS_SYS_CTRL1);
   wire wr_tog_ovf = wr & (ofs == `OFS_TOG_OVF);
   wire wr_sys_ctrl2 = wr & (ofs == `OFS_SYS_CTRL2);
   wire wr_flags = wr & (ofs == `OFS_FLAGS);
   wire wr_acc = wr & (ofs == `OFS_ACC_COUNT);
   wire wr_irq_mask = wr & (ofs == `OFS_IRQ_MASK);
   wire wr_port = wr & (ofs == `OFS_PORT_DATA);

   wire enabled = sys_ctrl1_q[`BIT_GLOBAL_EN];
   wire fast_clr = sys_ctrl1_q[`BIT_FAST_CLR];
   wire cnt_rst_ch3 = sys_ctrl2_q[`BIT_CNT_RST_CH3];
   wire [6:0] presc_mask = (7'h01 << sys_ctrl2_q[2:0]) - 7'h01;
   // Tick every 2^n bus cycles; held off entirely while disabled
   wire tick = enabled & (presc_q == presc_mask);
   wire cnt_access = done & (ofs == `OFS_COUNT);
   wire acc_access = done & (ofs == `OFS_ACC_COUNT);
   wire cnt_wr = wr & (ofs == `OFS_COUNT) & test_mode;
   wire wrap = tick & (count_q == `CNT_ALL_ONES);
   wire ch3_reset = tick & cnt_rst_ch3 & (count_q == ch_q[3]);
   // A ch3 reset from 0xFFFF is not an overflow
   wire ovf_evt = wrap & ~(cnt_rst_ch3 & (ch_q[3] == `CNT_ALL_ONES));
   wire [3:0] rise = timer_pin_in & ~pin_in_q;
   wire acc_evt = enabled & rise[3] & ~func_sel_q[3];
   wire acc_wrap = acc_evt & (acc_q == `CNT_ALL_ONES);

   reg [3:0] cmp_hit;
   reg [3:0] cap_hit;
   reg [3:0] fc_ch;
   integer i;
   integer j;
   integer k;

   // Per-channel compare, capture and fast-clear decode
   always @* begin
      for (i = 0; i < 4; i = i + 1) begin
         cmp_hit[i] = tick & func_sel_q[i] & (count_q == ch_q[i]);
         cap_hit[i] = enabled & ~func_sel_q[i] & rise[i];
         fc_ch[i] = fast_clr & (ofs == ch_ofs(i[1:0])) &
            ((rd & ~func_sel_q[i]) | (wr & func_sel_q[i]));
      end
   end

   // Counter next value
   always @* begin
      count_d = count_q;
      if (cnt_wr) begin
         count_d = pwdata[15:0];
      end else if (ch3_reset) begin
         count_d = `RST_WORD;
      end else if (tick) begin
         count_d = count_q + 16'h0001;
      end
   end

   // Flags: fast-clear or write-one clear, but a new event always wins
   always @* begin
      flags_d = flags_q;
      if (wr_flags & ~fast_clr) begin
         flags_d = flags_q & ~pwdata[6:0];
      end
      flags_d[3:0] = flags_d[3:0] & ~fc_ch;
      if (fast_clr & cnt_access) begin
         flags_d[`BIT_FLG_OVF] = 1'b0;
      end
      if (fast_clr & acc_access) begin
         flags_d[`BIT_FLG_ACC_OVF] = 1'b0;
         flags_d[`BIT_FLG_ACC_IN] = 1'b0;
      end
      flags_d[3:0] = flags_d[3:0] | cmp_hit | cap_hit;
      if (ovf_evt) begin
         flags_d[`BIT_FLG_OVF] = 1'b1;
      end
      if (acc_wrap) begin
         flags_d[`BIT_FLG_ACC_OVF] = 1'b1;
      end
      if (acc_evt) begin
         flags_d[`BIT_FLG_ACC_IN] = 1'b1;
      end
   end

   // Port data: software write first, then compare actions override it
   always @* begin
      port_d = port_q;
      if (wr_port) begin
         port_d = pwdata[3:0];
      end
      for (j = 0; j < 4; j = j + 1) begin
         if (func_sel_q[j]) begin
            port_d[j] = next_pin(port_d[j],
               cmp_hit[3] & ovr_mask_q[j],
               ovr_data_q[j],
               wrap & tog_ovf_q[j],
               cmp_hit[j] | force_q[j]);
         end
      end
   end

   // Prescaler, restarted by a counter write so it never splits a count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_q <= 7'h00;
      end else if (cnt_wr | ~enabled | tick) begin
         presc_q <= 7'h00;
      end else begin
         presc_q <= presc_q + 7'h01;
      end
   end

   // Timer state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= `RST_WORD;
         flags_q <= 7'h00;
         port_q <= 4'h0;
         pin_in_q <= 4'h0;
         acc_q <= `RST_WORD;
         for (k = 0; k < 4; k = k + 1) begin
            ch_q[k] <= `RST_WORD;
         end
      end else begin
         count_q <= count_d;
         flags_q <= flags_d;
         port_q <= port_d;
         pin_in_q <= timer_pin_in;
         if (wr_acc) begin
            acc_q <= pwdata[15:0];
         end else if (acc_evt) begin
            acc_q <= acc_q + 16'h0001;
         end
         for (k = 0; k < 4; k = k + 1) begin
            if (cap_hit[k]) begin
               ch_q[k] <= count_q; // Capture wins over a write
            end else if (wr & (ofs == ch_ofs(k[1:0]))) begin
               ch_q[k] <= pwdata[15:0];
            end
         end
      end
   end

   // Configuration registers, writable whether or not the timer runs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_sel_q <= 4'h0;
         ovr_mask_q <= 4'h0;
         ovr_data_q <= 4'h0;
         sys_ctrl1_q <= `RST_BYTE;
         tog_ovf_q <= 4'h0;
         sys_ctrl2_q <= `RST_BYTE;
         irq_mask_q <= 7'h00;
         force_q <= 4'h0;
      end else begin
         // Force is a one-cycle strobe, never stored
         force_q <= wr_force ? pwdata[3:0] : 4'h0;
         if (wr_func_sel) begin
            func_sel_q <= pwdata[3:0];
         end
         if (wr_ovr_mask) begin
            ovr_mask_q <= pwdata[3:0];
         end
         if (wr_ovr_data) begin
            ovr_data_q <= pwdata[3:0];
         end
         if (wr_sys_ctrl1) begin
            sys_ctrl1_q <= pwdata[7:0] & 8'h90;
         end
         if (wr_tog_ovf) begin
            tog_ovf_q <= pwdata[3:0];
         end
         if (wr_sys_ctrl2) begin
            sys_ctrl2_q <= pwdata[7:0] & 8'h0F;
         end
         if (wr_irq_mask) begin
            irq_mask_q <= pwdata[6:0];
         end
      end
   end

   // APB: no wait state; read data and error decoded in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= 1'b0;
         if (setup) begin
            prdata <= 32'h0000_0000;
            case (ofs)
               `OFS_FUNC_SEL: prdata[3:0] <= func_sel_q;
               `OFS_FORCE: prdata[3:0] <= 4'h0;
               `OFS_OVR_MASK: prdata[3:0] <= ovr_mask_q;
               `OFS_OVR_DATA: prdata[3:0] <= ovr_data_q;
               `OFS_COUNT: prdata[15:0] <= count_q;
               `OFS_SYS_CTRL1: prdata[7:0] <= sys_ctrl1_q;
               `OFS_TOG_OVF: prdata[3:0] <= tog_ovf_q;
               `OFS_SYS_CTRL2: prdata[7:0] <= sys_ctrl2_q;
               `OFS_FLAGS: prdata[6:0] <= flags_q;
               `OFS_CH0: prdata[15:0] <= ch_q[0];
               `OFS_CH1: prdata[15:0] <= ch_q[1];
               `OFS_CH2: prdata[15:0] <= ch_q[2];
               `OFS_CH3: prdata[15:0] <= ch_q[3];
               `OFS_ACC_COUNT: prdata[15:0] <= acc_q;
               `OFS_IRQ_MASK: prdata[6:0] <= irq_mask_q;
               `OFS_PORT_DATA: prdata[3:0] <= port_q;
               default: pslverr <= 1'b1; // Unmapped: error, no effect
            endcase
         end
      end
   end

   // Pins and interrupt, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_pin_out <= 4'h0;
         timer_pin_oe <= 4'h0;
         irq <= 1'b0;
      end else begin
         timer_pin_out <= port_d;
         timer_pin_oe <= func_sel_q;
         irq <= |(flags_d & irq_mask_q);
      end
   end

endmodule // timer_counter_control_core

// *** timer_counter_control_core_tb.sv ***
/* Self-checking APB bench for the timer core.
   Assumes the header map; pins in stay low but for one pin 3 rise, which feeds the accumulator and a channel 3 capture. */
`timescale 1ns/1ps
`include "timer_counter_map.vh"
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin \
 mismatches++; $display("wrong value %s exp %h got %h", n, x, g); end end
module timer_counter_control_core_tb;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg test_mode = 0, e;
   reg [31:0] paddr = 0, pwdata = 0, d, c0;
   reg [3:0] pin_in = 4'h0;
   reg [7:0] fc = 8'h00;
   wire [31:0] prdata;
   wire pready, pslverr, irq;
   wire [3:0] pin_out, pin_oe;
   int mismatches = 0, samples_checked = 0, cyc = 0;
   // 100 MHz clock
   always #5 pclk = ~pclk;
   timer_counter_control_core dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .test_mode(test_mode), .timer_pin_in(pin_in),
      .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .irq(irq));
   // One APB transfer; waits for ready, the watchdog bounds it
   task xfer(input w, input [7:0] a, input [31:0] v);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w;
      paddr <= {24'h00_0000, a}; pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // Load the counter, run n cycles, stop again
   task burst(input [15:0] s, input int n);
      xfer(1, `OFS_COUNT, {16'h0000, s});
      xfer(1, `OFS_SYS_CTRL1, {24'h00_0000, fc | 8'h80});
      repeat (n) @(posedge pclk);
      xfer(1, `OFS_SYS_CTRL1, {24'h00_0000, fc});
   endtask
   task give_verdict;
      $display("mismatches %0d samples_checked %0d", mismatches,
         samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog: the whole sequence needs well under 1000 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         give_verdict;
      end
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      xfer(0, `OFS_COUNT, 0); `CHK("count", 32'h0000_0000, d)
      xfer(0, 8'h34, 0); `CHK("hole err", 1'b1, e)
      xfer(1, `OFS_COUNT, 32'h0000_1234);
      xfer(0, `OFS_COUNT, 0); `CHK("count", 32'h0000_0000, d)
      test_mode <= 1;
      xfer(1, `OFS_COUNT, 32'h0000_1234);
      xfer(0, `OFS_COUNT, 0); `CHK("count", 32'h0000_1234, d)
      xfer(1, `OFS_FUNC_SEL, 32'h0000_000F);
      xfer(1, `OFS_OVR_MASK, 32'h0000_0005);
      xfer(1, `OFS_OVR_DATA, 32'h0000_0004);
      xfer(1, `OFS_CH0, 32'h0000_0100);
      xfer(1, `OFS_CH1, 32'h0000_0100);
      xfer(1, `OFS_CH2, 32'h0000_0100);
      xfer(1, `OFS_CH3, 32'h0000_0100);
      xfer(1, `OFS_IRQ_MASK, 32'h0000_0010);
      // Back-to-back reads are three cycles apart at one tick per cycle
      xfer(1, `OFS_COUNT, 32'h0000_00FC);
      xfer(1, `OFS_SYS_CTRL1, 32'h0000_0080);
      xfer(0, `OFS_COUNT, 0); c0 = d;
      xfer(0, `OFS_COUNT, 0); `CHK("step", c0 + 3, d)
      repeat (10) @(posedge pclk);
      xfer(1, `OFS_SYS_CTRL1, 32'h0000_0000);
      xfer(0, `OFS_COUNT, 0); c0 = d;
      repeat (5) @(posedge pclk);
      xfer(0, `OFS_COUNT, 0); `CHK("held", c0, d)
      `CHK("pins", 4'b1110, pin_out)
      `CHK("oe", 4'hF, pin_oe)
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_000F, d)
      // Overflow toggles pins 0 and 1 and raises the masked interrupt
      xfer(1, `OFS_TOG_OVF, 32'h0000_0003);
      burst(16'hFFFE, 8);
      `CHK("pins", 4'b1101, pin_out)
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_001F, d)
      `CHK("irq", 1'b1, irq)
      xfer(1, `OFS_FLAGS, 32'h0000_0011);
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_000E, d)
      `CHK("irq", 1'b0, irq)
      fc = 8'h10;
      xfer(1, `OFS_SYS_CTRL1, 32'h0000_0010);
      xfer(1, `OFS_FLAGS, 32'h0000_0002);
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_000E, d)
      xfer(1, `OFS_CH1, 32'h0000_0100);
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_000C, d)
      burst(16'hFFFE, 8);
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_001C, d)
      xfer(0, `OFS_COUNT, 0);
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_000C, d)
      // Reset on channel 3 at all ones must not flag an overflow
      xfer(1, `OFS_SYS_CTRL2, 32'h0000_0008);
      xfer(1, `OFS_CH3, 32'h0000_FFFF);
      burst(16'hFFF0, 30);
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_000C, d)
      // Pin 3 rise with channel 3 as input feeds the accumulator
      xfer(1, `OFS_FUNC_SEL, 32'h0000_0007);
      xfer(1, `OFS_SYS_CTRL1, 32'h0000_0090);
      pin_in <= 4'h8;
      xfer(1, `OFS_SYS_CTRL1, 32'h0000_0010);
      pin_in <= 4'h0;
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_004C, d)
      xfer(0, `OFS_ACC_COUNT, 0); `CHK("acc", 32'h0000_0001, d)
      xfer(0, `OFS_FLAGS, 0); `CHK("flags", 32'h0000_000C, d)
      give_verdict;
   end
endmodule // timer_counter_control_core_tb

// *** timer_counter_map.vh ***
/*
 * Register offsets, field positions and reset values of the timer core.
 * Assumes a 32-bit APB bus with one aligned word per register.
 */
`ifndef TIMER_COUNTER_MAP_VH
`define TIMER_COUNTER_MAP_VH

// Byte offsets (paddr[7:0])
`define OFS_FUNC_SEL 8'h00
`define OFS_FORCE 8'h04
`define OFS_OVR_MASK 8'h08
`define OFS_OVR_DATA 8'h0C
`define OFS_COUNT 8'h10
`define OFS_SYS_CTRL1 8'h14
`define OFS_TOG_OVF 8'h18
`define OFS_SYS_CTRL2 8'h1C
`define OFS_FLAGS 8'h20
`define OFS_CH0 8'h24
`define OFS_CH1 8'h28
`define OFS_CH2 8'h2C
`define OFS_CH3 8'h30
`define OFS_ACC_COUNT 8'h38
`define OFS_IRQ_MASK 8'h40
`define OFS_PORT_DATA 8'h44

// Field positions
`define BIT_GLOBAL_EN 7
`define BIT_FAST_CLR 4
`define BIT_CNT_RST_CH3 3
`define BIT_FLG_OVF 4
`define BIT_FLG_ACC_OVF 5
`define BIT_FLG_ACC_IN 6

// Reset values and limits
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define CNT_ALL_ONES 16'hFFFF

`endif
